// >>> design/rxcfc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rxcfc_mem (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [rxcfc_pkg::PTR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [rxcfc_pkg::PTR_W-1:0] rd_addr,
    output var logic [7:0] rd_data
);

    logic [7:0] mem [rxcfc_pkg::BUF_DEPTH];

    // Storage write
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, holds until next read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // rxcfc_mem
`default_nettype wire

// >>> design/rxcfc_pkg.sv
package rxcfc_pkg;

    // Control and special character codes
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_HT = 8'h09;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_VT = 8'h0B;
    localparam logic [7:0] CH_FF = 8'h0C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SO = 8'h0E;
    localparam logic [7:0] CH_SI = 8'h0F;
    localparam logic [7:0] CH_DLE = 8'h10;
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_CAN = 8'h18;
    localparam logic [7:0] CH_SUB = 8'h1A;
    localparam logic [7:0] CH_ESC = 8'h1B;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_SEQ_INTRO = 8'h5B;
    localparam logic [7:0] CH_FINAL_LO = 8'h40;
    localparam logic [7:0] CH_DEL = 8'h7F;

    // Input buffer geometry
    localparam int BUF_DEPTH = 1000;
    localparam int PTR_W = 10;
    localparam logic [PTR_W-1:0] PTR_LAST = 10'h3E7;
    localparam logic [PTR_W:0] CNT_FULL = 11'h3E8;

    // Water marks: small 50/60, large 256/576
    localparam logic [PTR_W:0] LOW_SMALL = 11'h032;
    localparam logic [PTR_W:0] HIGH_SMALL = 11'h03C;
    localparam logic [PTR_W:0] LOW_LARGE = 11'h100;
    localparam logic [PTR_W:0] HIGH_LARGE = 11'h240;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HMARG = 8'h04;
    localparam logic [7:0] ADDR_VMARG = 8'h08;
    localparam logic [7:0] ADDR_TAB = 8'h0C;
    localparam logic [7:0] ADDR_POS = 8'h10;
    localparam logic [7:0] ADDR_FILL = 8'h14;

    // Tab register fields
    localparam int TAB_VAL_BIT = 8;
    localparam int TAB_VERT_BIT = 9;

    // Values after reset
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [7:0] LEFT_RST = 8'h01;
    localparam logic [7:0] RIGHT_RST = 8'h84;
    localparam logic [7:0] TOP_RST = 8'h01;
    localparam logic [7:0] BOTTOM_RST = 8'h42;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register, bit 8 first
    typedef struct packed {
        logic tx_en;
        logic hdx_eot;
        logic buf_large;
        logic proto_fdx;
        logic sec_chan;
        logic xon_en;
        logic alt_set_en;
        logic cr_newline;
        logic lnm;
    } rxcfc_cfg_s;

    // Character handed to the print engine
    typedef struct packed {
        logic alt_set;
        logic err_glyph;
        logic [7:0] line;
        logic [7:0] col;
        logic [7:0] code;
    } rxcfc_prt_s;

endpackage

// >>> design/rxcfc_top.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Backspace steps column back, not past left
// R2 - Tab goes to next stop, else right+1
// R3 - Line feed advances; at bottom, next top
// R4 - Newline option returns column on LF/VT/FF
// R5 - Vertical tab to next stop, else top
// R6 - Form feed goes to next page top
// R7 - Return goes left; optionally also new line
// R8 - Shift-in selects primary set if fitted
// R9 - Shift-out selects secondary if fitted, enabled
// R10 - DLE before EOT means disconnect, half-duplex
// R11 - Cancel drops pending escape sequence
// R12 - Parity-error characters become substitute
// R13 - Overflow loss leaves one substitute marker
// R14 - Substitute prints error glyph, cancels escape
// R15 - Buffer all but NUL/DEL; printer drains
// R16 - Pause above high mark, resume below low
// R17 - Water marks 50/60 or 256/576
// R18 - Blocked printer also requests pause
// R19 - Signal by XON/XOFF and/or request line
// R20 - Restraint only with secondary, plain full duplex
// R21 - XON/XOFF only when enabled
// R22 - XOFF may follow a sent keyboard character
// R23 - One XON after power-up when transmitting
// R24 - Source stops promptly on pause
module rxcfc_top (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_err,
    output logic prt_valid,
    input wire logic prt_ready,
    output rxcfc_pkg::rxcfc_prt_s prt_data,
    input wire logic kb_valid,
    input wire logic [7:0] kb_data,
    output logic kb_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic secondary_request_to_send,
    output logic disconnect_req,
    input wire logic paper_out,
    input wire logic head_jam,
    input wire logic cover_open,
    input wire logic setup_mode,
    input wire logic alt_set_fitted
);

    // Nearest set stop above cur and not past lim, else lim+1
    function automatic logic [7:0] next_stop(input logic [255:0] stops, input logic [7:0] cur,
                                             input logic [7:0] lim);
        logic [7:0] res;
        res = lim + 8'h01;
        for (int i = 255; i >= 0; i--) begin
            if (stops[i] && (i > int'(cur)) && (i <= int'(lim))) begin
                res = 8'(i);
            end
        end
        return res;
    endfunction

    // Register address decode
    function automatic logic addr_ok(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (a == rxcfc_pkg::ADDR_CTRL) begin
            ok = 1'b1;
        end else if (a == rxcfc_pkg::ADDR_HMARG) begin
            ok = 1'b1;
        end else if (a == rxcfc_pkg::ADDR_VMARG) begin
            ok = 1'b1;
        end else if (a == rxcfc_pkg::ADDR_TAB) begin
            ok = 1'b1;
        end else if (a == rxcfc_pkg::ADDR_POS) begin
            ok = 1'b1;
        end else if (a == rxcfc_pkg::ADDR_FILL) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [rxcfc_pkg::PTR_W-1:0] ptr_inc(input logic [rxcfc_pkg::PTR_W-1:0] p);
        return (p == rxcfc_pkg::PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    rxcfc_pkg::rxcfc_cfg_s cfg_q;
    logic [15:0] hmarg_q;
    logic [15:0] vmarg_q;
    logic [255:0] htab_q;
    logic [255:0] vtab_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] aw_addr_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic do_wr;
    logic [31:0] m_cfg;
    logic [31:0] m_hm;
    logic [31:0] m_vm;
    logic [4:0] pin_meta_q;
    logic [4:0] pin_q;
    logic [rxcfc_pkg::PTR_W-1:0] wr_ptr_q;
    logic [rxcfc_pkg::PTR_W-1:0] rd_ptr_q;
    logic [rxcfc_pkg::PTR_W:0] cnt_q;
    logic full;
    logic lost_q;
    logic [7:0] in_data;
    logic in_keep;
    logic ins_sub;
    logic wr_en;
    logic [7:0] wr_data;
    logic rd_en;
    logic hold_v_q;
    logic [7:0] buf_data;
    logic consume;
    logic [7:0] col_q;
    logic [7:0] line_q;
    logic [7:0] line_adv;
    logic [7:0] ht_stop;
    logic [7:0] vt_stop;
    logic esc_q;
    logic alt_q;
    logic dle_rx_q;
    logic dle_tx_q;
    logic graphic;
    logic pause_lvl_q;
    logic want_pause;
    logic sent_pause_q;
    logic rep_xoff_q;
    logic flow_req;
    logic tx_load;

    // Pin inputs through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= 5'h00;
            pin_q <= 5'h00;
        end else begin
            pin_meta_q <= {alt_set_fitted, setup_mode, cover_open, head_jam, paper_out};
            pin_q <= pin_meta_q;
        end
    end

    // Write channel capture, either order
    assign awready = !aw_got_q;
    assign wready = !w_got_q;
    assign do_wr = aw_got_q && w_got_q && !bvalid;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (do_wr) begin
                aw_got_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                wd_q <= wdata;
                ws_q <= wstrb;
            end else if (do_wr) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= rxcfc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= addr_ok(aw_addr_q) ? rxcfc_pkg::RESP_OKAY : rxcfc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    assign m_cfg = wmerge({23'h0, cfg_q}, wd_q, ws_q);
    assign m_hm = wmerge({16'h0, hmarg_q}, wd_q, ws_q);
    assign m_vm = wmerge({16'h0, vmarg_q}, wd_q, ws_q);

    // Configuration and margin registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= rxcfc_pkg::CTRL_RST;
            hmarg_q <= {rxcfc_pkg::RIGHT_RST, rxcfc_pkg::LEFT_RST};
            vmarg_q <= {rxcfc_pkg::BOTTOM_RST, rxcfc_pkg::TOP_RST};
        end else if (do_wr) begin
            if (aw_addr_q == rxcfc_pkg::ADDR_CTRL) begin
                cfg_q <= m_cfg[8:0];
            end else if (aw_addr_q == rxcfc_pkg::ADDR_HMARG) begin
                hmarg_q <= m_hm[15:0];
            end else if (aw_addr_q == rxcfc_pkg::ADDR_VMARG) begin
                vmarg_q <= m_vm[15:0];
            end
        end
    end

    // Tab stops, one set or clear per write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            htab_q <= '0;
            vtab_q <= '0;
        end else if (do_wr && (aw_addr_q == rxcfc_pkg::ADDR_TAB) && ws_q[0] && ws_q[1]) begin
            if (wd_q[rxcfc_pkg::TAB_VERT_BIT]) begin
                vtab_q[wd_q[7:0]] <= wd_q[rxcfc_pkg::TAB_VAL_BIT];
            end else begin
                htab_q[wd_q[7:0]] <= wd_q[rxcfc_pkg::TAB_VAL_BIT];
            end
        end
    end

    // Read channel
    assign arready = !rvalid;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rxcfc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= addr_ok(araddr) ? rxcfc_pkg::RESP_OKAY : rxcfc_pkg::RESP_SLVERR;
            if (araddr == rxcfc_pkg::ADDR_CTRL) begin
                rdata <= {23'h0, cfg_q};
            end else if (araddr == rxcfc_pkg::ADDR_HMARG) begin
                rdata <= {16'h0, hmarg_q};
            end else if (araddr == rxcfc_pkg::ADDR_VMARG) begin
                rdata <= {16'h0, vmarg_q};
            end else if (araddr == rxcfc_pkg::ADDR_POS) begin
                rdata <= {13'h0, want_pause, esc_q, alt_q, line_q, col_q};
            end else if (araddr == rxcfc_pkg::ADDR_FILL) begin
                rdata <= {16'h0, pin_q[3:0], lost_q, cnt_q};
            end else begin
                rdata <= 32'h0000_0000;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Buffer fill: substitution, fill filtering, loss marker
    assign in_data = rx_parity_err ? rxcfc_pkg::CH_SUB : rx_data; // [R12]
    assign in_keep = (in_data != rxcfc_pkg::CH_NUL) && (in_data != rxcfc_pkg::CH_DEL); // [R15]
    assign full = (cnt_q == rxcfc_pkg::CNT_FULL);
    assign ins_sub = lost_q && !full; // [R13]
    assign wr_en = ins_sub || (rx_valid && in_keep && !full);
    assign wr_data = ins_sub ? rxcfc_pkg::CH_SUB : in_data;
    assign consume = hold_v_q && (!prt_valid || prt_ready);
    assign rd_en = (cnt_q != '0) && (!hold_v_q || consume); // [R15]

    // Pointers, count and loss flag; a new loss beats the clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            lost_q <= 1'b0;
            hold_v_q <= 1'b0;
        end else begin
            if (wr_en) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (rd_en) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            cnt_q <= cnt_q + {10'h0, wr_en} - {10'h0, rd_en};
            if (rx_valid && in_keep && (full || ins_sub)) begin
                lost_q <= 1'b1; // [R13]
            end else if (ins_sub) begin
                lost_q <= 1'b0;
            end
            hold_v_q <= rd_en || (hold_v_q && !consume);
        end
    end

    rxcfc_mem u_mem (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_addr(wr_ptr_q),
        .wr_data(wr_data),
        .rd_en(rd_en),
        .rd_addr(rd_ptr_q),
        .rd_data(buf_data)
    );

    // Position helpers
    assign line_adv = ((line_q >= vmarg_q[15:8]) || (line_q < vmarg_q[7:0])) ? vmarg_q[7:0]
                      : line_q + 8'h01; // [R3]
    assign ht_stop = next_stop(htab_q, col_q, hmarg_q[15:8]); // [R2]
    assign vt_stop = next_stop(vtab_q, line_q, vmarg_q[15:8]); // [R5]
    assign graphic = (buf_data >= rxcfc_pkg::CH_SP) && (buf_data < rxcfc_pkg::CH_DEL);

    // Active column and line
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            col_q <= rxcfc_pkg::LEFT_RST;
            line_q <= rxcfc_pkg::TOP_RST;
        end else if (consume && !esc_q) begin
            case (buf_data)
                rxcfc_pkg::CH_BS: begin
                    if (col_q != hmarg_q[7:0]) begin
                        col_q <= col_q - 8'h01; // [R1]
                    end
                end
                rxcfc_pkg::CH_HT: begin
                    col_q <= ht_stop; // [R2]
                end
                rxcfc_pkg::CH_LF: begin
                    line_q <= line_adv; // [R3]
                    if (cfg_q.lnm) begin
                        col_q <= hmarg_q[7:0]; // [R4]
                    end
                end
                rxcfc_pkg::CH_VT: begin
                    line_q <= (vt_stop == vmarg_q[15:8] + 8'h01) ? vmarg_q[7:0] : vt_stop; // [R5]
                    if (cfg_q.lnm) begin
                        col_q <= hmarg_q[7:0]; // [R4]
                    end
                end
                rxcfc_pkg::CH_FF: begin
                    line_q <= vmarg_q[7:0]; // [R6]
                    if (cfg_q.lnm) begin
                        col_q <= hmarg_q[7:0]; // [R4]
                    end
                end
                rxcfc_pkg::CH_CR: begin
                    col_q <= hmarg_q[7:0]; // [R7]
                    if (cfg_q.cr_newline) begin
                        line_q <= line_adv; // [R7]
                    end
                end
                default: begin
                    if ((graphic || buf_data == rxcfc_pkg::CH_SUB) && col_q <= hmarg_q[15:8]) begin
                        col_q <= col_q + 8'h01;
                    end
                end
            endcase
        end
    end

    // Escape state, character set, link escape
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            esc_q <= 1'b0;
            alt_q <= 1'b0;
            dle_rx_q <= 1'b0;
        end else if (consume) begin
            if (buf_data == rxcfc_pkg::CH_CAN || buf_data == rxcfc_pkg::CH_SUB) begin
                esc_q <= 1'b0; // [R11] [R14]
            end else if (buf_data == rxcfc_pkg::CH_ESC) begin
                esc_q <= 1'b1;
            end else if (esc_q && buf_data >= rxcfc_pkg::CH_FINAL_LO && graphic
                         && buf_data != rxcfc_pkg::CH_SEQ_INTRO) begin
                esc_q <= 1'b0;
            end
            if (buf_data == rxcfc_pkg::CH_SI && pin_q[4]) begin
                alt_q <= 1'b0; // [R8]
            end else if (buf_data == rxcfc_pkg::CH_SO && pin_q[4] && cfg_q.alt_set_en) begin
                alt_q <= 1'b1; // [R9]
            end
            dle_rx_q <= (buf_data == rxcfc_pkg::CH_DLE);
        end
    end

    // Disconnect request on escaped EOT
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            disconnect_req <= 1'b0;
        end else begin
            disconnect_req <= consume && (buf_data == rxcfc_pkg::CH_EOT) && cfg_q.hdx_eot
                              && (dle_rx_q || dle_tx_q); // [R10]
        end
    end

    // Print output stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prt_valid <= 1'b0;
            prt_data <= '0;
        end else if (consume && (buf_data == rxcfc_pkg::CH_SUB || (graphic && !esc_q))) begin
            prt_valid <= 1'b1;
            prt_data <= '{alt_set: alt_q, err_glyph: (buf_data == rxcfc_pkg::CH_SUB),
                          line: line_q, col: col_q, code: buf_data}; // [R14]
        end else if (prt_ready) begin
            prt_valid <= 1'b0;
        end
    end

    // Water marks with hysteresis, blocked printer forces pause
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pause_lvl_q <= 1'b0;
        end else if (cnt_q > (cfg_q.buf_large ? rxcfc_pkg::HIGH_LARGE : rxcfc_pkg::HIGH_SMALL)) begin
            pause_lvl_q <= 1'b1; // [R16] [R17]
        end else if (cnt_q < (cfg_q.buf_large ? rxcfc_pkg::LOW_LARGE : rxcfc_pkg::LOW_SMALL)) begin
            pause_lvl_q <= 1'b0; // [R16] [R17]
        end
    end
    assign want_pause = pause_lvl_q || (|pin_q[3:0]); // [R18]

    // Restraint line, high while the source may send
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            secondary_request_to_send <= 1'b0;
        end else begin
            secondary_request_to_send <= cfg_q.sec_chan && cfg_q.proto_fdx && !want_pause; // [R19] [R20]
        end
    end

    // Flow characters take the transmitter ahead of the keyboard
    assign flow_req = cfg_q.xon_en && ((want_pause != sent_pause_q) || rep_xoff_q); // [R21]
    assign tx_load = cfg_q.tx_en && (!tx_valid || tx_ready);
    assign kb_ready = tx_load && !flow_req;

    // Transmit holding stage; sent state starts paused so the first XON goes out
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            sent_pause_q <= 1'b1; // [R23]
            rep_xoff_q <= 1'b0;
            dle_tx_q <= 1'b0;
        end else if (tx_load && flow_req) begin
            tx_valid <= 1'b1;
            tx_data <= want_pause ? rxcfc_pkg::CH_XOFF : rxcfc_pkg::CH_XON; // [R19] [R23]
            sent_pause_q <= want_pause;
            rep_xoff_q <= 1'b0;
        end else if (tx_load && kb_valid) begin
            tx_valid <= 1'b1;
            tx_data <= kb_data;
            rep_xoff_q <= want_pause && cfg_q.xon_en; // [R22]
            dle_tx_q <= (kb_data == rxcfc_pkg::CH_DLE); // [R10]
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

endmodule // rxcfc_top
`default_nettype wire

// >>> sim/rxcfc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rxcfc_assertions (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic prt_valid,
    input wire logic prt_ready,
    input wire rxcfc_pkg::rxcfc_prt_s prt_data,
    input wire logic kb_valid,
    input wire logic kb_ready,
    input wire logic [7:0] kb_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic secondary_request_to_send,
    input wire logic disconnect_req,
    input wire logic head_jam
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Jam pin raised and held long enough to pass the synchronizer
    sequence s_jam;
        $rose(head_jam) ##1 head_jam [*5];
    endsequence
    a_prt_holds: assert property (prt_valid && !prt_ready |=> prt_valid && $stable(prt_data))
        else $error("print output dropped");
    a_no_fill: assert property (prt_valid |-> prt_data.code != 8'h00 && prt_data.code != 8'h7F)
        else $error("fill char printed");
    a_sub_glyph: assert property (prt_valid |-> (prt_data.code == 8'h1A) == prt_data.err_glyph)
        else $error("glyph mismatch");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx dropped");
    a_kb_sent: assert property (kb_valid && kb_ready |=> tx_valid && tx_data == $past(kb_data))
        else $error("key not sent");
    a_kb_blocked: assert property (tx_valid && !tx_ready |-> !kb_ready)
        else $error("key taken while busy");
    a_disc_pulse: assert property (disconnect_req |=> !disconnect_req)
        else $error("disconnect too long");
    a_jam_pause: assert property (s_jam |-> !secondary_request_to_send)
        else $error("no pause on jam");
endmodule // rxcfc_assertions
bind rxcfc_top rxcfc_assertions u_chk (.*);
`default_nettype wire

// >>> sim/rxcfc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rxcfc_host (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_parity_err
);
    logic [8:0] q[$];
    logic paused_q;
    // Takes sent characters, slowly on request; follows pause state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'h0;
            paused_q <= 1'h0;
        end else begin
            tx_ready <= slow ? !tx_ready : 1'h1;
            if (tx_valid && tx_ready && tx_data == 8'h13) paused_q <= 1'h1;
            if (tx_valid && tx_ready && tx_data == 8'h11) paused_q <= 1'h0;
        end
    end
    // Sends queued characters on alternate cycles unless paused
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid <= 1'h0;
            rx_data <= 8'h00;
            rx_parity_err <= 1'h0;
        end else if (!rx_valid && !paused_q && q.size() != 0) begin
            rx_valid <= 1'h1;
            {rx_parity_err, rx_data} <= q.pop_front();
        end else begin
            rx_valid <= 1'h0;
            rx_data <= ~rx_data;
            rx_parity_err <= 1'h0;
        end
    end
endmodule // rxcfc_host
`default_nettype wire

// >>> sim/test_rx_control_char_and_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_control_char_and_flow_ctrl;
    logic mclk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
    logic rready = 1'h0, kb_valid = 1'h0, pr = 1'h1, head_jam = 1'h0, slow = 1'h0, awready, wready;
    logic bvalid, arready, rvalid, prt_valid, kb_ready, tx_valid, tx_ready, rx_valid, rx_parity_err;
    logic secondary_request_to_send, disconnect_req, fit = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, kb_data = 8'h00, tx_data, rx_data;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    rxcfc_pkg::rxcfc_prt_s prt_data;
    logic [25:0] pq[$];
    logic [7:0] tq[$];
    logic [25:0] ex[8] = '{26'h10141, 26'h10142, 26'h101021A, 26'h20143, 26'h10144, 26'h10145,
        26'h2010246, 26'h10147};
    int failures = 0, num_checks = 0, cyc = 0, dn = 0;
    rxcfc_top DUT (.*, .wstrb(4'hF), .prt_ready(pr), .paper_out(1'h0), .cover_open(1'h0),
        .setup_mode(1'h0), .alt_set_fitted(fit));
    rxcfc_host host (.*);
    always #2.5 mclk = ~mclk;
    // Record prints, sent chars, disconnects; cut a hang short
    always @(posedge mclk) begin
        if (prt_valid && pr) pq.push_back(prt_data);
        if (tx_valid && tx_ready) tq.push_back(tx_data);
        if (disconnect_req) dn++;
        cyc++;
        if (cyc == 30000) begin
            failures++;
            results();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa = 1'h1, pw = 1'h1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (pa || pw) begin
            @(negedge mclk);
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge mclk);
            if (!pa) awvalid <= 1'h0;
            if (!pw) wvalid <= 1'h0;
        end
        do @(negedge mclk); while (!bvalid);
        chk(bresp, 32'h0);
        @(posedge mclk);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge mclk); while (!arready);
        @(posedge mclk);
        arvalid <= 1'h0;
        do @(negedge mclk); while (!rvalid);
        chk(rdata, e);
        chk(rresp, r);
        @(posedge mclk);
    endtask
    task automatic put(input string s);
        foreach (s[i]) host.q.push_back({1'h0, s[i]});
    endtask
    task automatic wt(input int n);
        while (tq.size() < n) @(posedge mclk);
    endtask
    task automatic results();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        @(posedge mclk);
        rd(rxcfc_pkg::ADDR_HMARG, 32'h8401, 2'h0);
        rd(rxcfc_pkg::ADDR_VMARG, 32'h4201, 2'h0);
        rd(8'h18, 32'h0, rxcfc_pkg::RESP_SLVERR);
        wr(rxcfc_pkg::ADDR_CTRL, 32'h1BD);
        wt(1);
        chk(tq[0], 8'h11);
        put("A");
        host.q.push_back(9'h000);
        put("\010\010B\177");
        host.q.push_back(9'h135);
        put("\012C\013D\011");
        while (pq.size() < 5) @(posedge mclk);
        repeat (30) @(posedge mclk);
        rd(rxcfc_pkg::ADDR_POS, 32'h185, 2'h0);
        put("\015\033\030E\016F\017\012\014G");
        while (pq.size() < 8) @(posedge mclk);
        foreach (ex[i]) chk(pq[i], ex[i]);
        chk(secondary_request_to_send, 1'h1);
        pr <= 1'h0;
        slow <= 1'h1;
        repeat (80) put("x");
        wt(2);
        chk(tq[1], 8'h13);
        repeat (4) @(posedge mclk);
        chk(secondary_request_to_send, 1'h0);
        pr <= 1'h1;
        wt(3);
        chk(tq[2], 8'h11);
        head_jam <= 1'h1;
        wt(4);
        chk(tq[3], 8'h13);
        kb_data <= 8'h6B;
        kb_valid <= 1'h1;
        do @(negedge mclk); while (!kb_ready);
        @(posedge mclk);
        kb_valid <= 1'h0;
        wt(6);
        chk(tq[4], 8'h6B);
        chk(tq[5], 8'h13);
        head_jam <= 1'h0;
        wt(7);
        chk(tq[6], 8'h11);
        put("\020\004");
        while (host.q.size() != 0) @(posedge mclk);
        repeat (300) @(posedge mclk);
        chk(dn, 32'h1);
        results();
    end
endmodule // test_rx_control_char_and_flow_ctrl
`default_nettype wire
